// File: tb/cwlo_partner.sv
// CW clock source model: fast, sync and external I/Q clocks.
// Assumes mode_in gives the ratio of fast to sync clock.
module cwlo_partner (
  // Mode
  input wire logic [1:0] mode_in,
  // Clocks
  output logic fast_out,
  output logic sync_out,
  output logic ext_i_out,
  output logic ext_q_out,
  output int slot_out
);
  timeunit 1ns;
  timeprecision 10ps;
  int t = 0;
  int n;
  initial begin
    forever begin
      n = (mode_in == 2'h3) ? 1 : 16 >> mode_in;
      slot_out = t / 4 % n;
      fast_out = t % 4 < 2;
      sync_out = t % (4 * n) < 2 * n;
      ext_i_out = sync_out;
      ext_q_out = (t + 3 * n) % (4 * n) < 2 * n;
      #31.25 t = t + 1;
    end
  end
endmodule // cwlo_partner

// File: tb/cwlo_top_assertions.sv
// Checker for the LO block's mode, harmonic and phase outputs.
// Assumes binding to cwlo_top.
module cwlo_top_assertions (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Watched ports
  input wire logic [1:0] mode_in,
  input wire logic mode_load_in,
  input wire logic harm_req_in,
  input wire logic [1:0] mode_out,
  input wire logic harm_en_out,
  input wire logic [3:0] phase_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  sequence s_load;
    mode_load_in ##2 1'b1;
  endsequence
  sequence s_low4;
    mode_out[1][*4];
  endsequence
  AST_RESET_MODE: assert property ($rose(resetn_in) |-> mode_out == 2'h0)
    else $error("mode after reset");
  AST_RESET_OUT: assert property ($rose(resetn_in) |-> !harm_en_out && phase_out == 4'h0)
    else $error("outputs after reset");
  AST_MODE_LOAD: assert property (s_load |-> mode_out == $past(mode_in, 2))
    else $error("mode load");
  AST_MODE_HOLD: assert property (!$past(mode_load_in, 2) && !$past(mode_load_in)
    |-> $stable(mode_out)) else $error("mode moved");
  AST_HARM_OFF: assert property (s_low4 |-> !$past(harm_en_out))
    else $error("harmonic on");
  AST_HARM_ON: assert property ((harm_req_in && !mode_out[1])[*4] |-> $past(harm_en_out))
    else $error("harmonic off");
  AST_PHASE_STEP: assert property (mode_out != 2'h3 && $stable(mode_out)
    && $past(mode_out) == $past(mode_out, 2) && $changed(phase_out)
    |-> phase_out == 4'h0 || phase_out == $past(phase_out) + (4'h1 << mode_out))
    else $error("phase step");
  AST_PHASE_1X: assert property ((mode_out == 2'h3)[*3] |-> phase_out == 4'h0
    || $stable(phase_out)) else $error("phase in 1x");
endmodule // cwlo_top_assertions
bind cwlo_top cwlo_top_assertions u_chk (.clock_in, .resetn_in, .mode_in, .mode_load_in,
  .harm_req_in, .mode_out, .harm_en_out, .phase_out);

// File: tb/cwlo_top_tb.sv
// Testbench for cwlo_top with a CW clock source model.
// Assumes the clock source follows the configured mode.
module cwlo_top_tb;
  timeunit 1ns;
  timeprecision 10ps;
  logic clock_in = 0, resetn_in = 0, mode_load_in = 0, harm_req_in = 0;
  logic fast, sync, ext_i, ext_q, lo_i, lo_q, harm_en;
  logic [1:0] mode_in = 0, mode_sel = 0, mode_out;
  logic [31:0] codes_in = 0, c;
  logic [7:0] rx_in = 0, lo_out;
  logic [3:0] phase_out;
  logic signed [13:0] sum_out;
  int error_cnt = 0, checked = 0, slot, k;
  logic [7:0] e;
  logic b;
  int p, s, v, cd;
  // Cosine of k sixteenths of a period, scaled by 127 and rounded
  function automatic int wt(input int k);
    real x;
    x = 127.0 * $cos(3.14159265358979 * k / 8.0);
    return $rtoi(x < 0.0 ? x - 0.5 : x + 0.5);
  endfunction
  cwlo_partner u_src (.mode_in(mode_sel), .fast_out(fast), .sync_out(sync),
    .ext_i_out(ext_i), .ext_q_out(ext_q), .slot_out(slot));
  cwlo_top DUT (.clock_in(clock_in), .resetn_in(resetn_in), .fast_clk_in(fast),
    .sync_clk_in(sync), .ext_i_in(ext_i), .ext_q_in(ext_q), .mode_in(mode_in),
    .mode_load_in(mode_load_in), .codes_in(codes_in), .harm_req_in(harm_req_in),
    .rx_in(rx_in), .mode_out(mode_out), .lo_out(lo_out), .lo_i_out(lo_i),
    .lo_q_out(lo_q), .harm_en_out(harm_en), .phase_out(phase_out), .sum_out(sum_out));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #4 clock_in = ~clock_in;
  initial begin
    #200us error_cnt++;
    complete_run;
  end
  initial begin
    k = $urandom(32'hc3c3);
    repeat (3) @(posedge clock_in);
    resetn_in <= 1;
    @(posedge clock_in);
    #1 check(mode_out, 0);
    for (int m = 0; m < 4; m++) begin
      for (int g = 0; g < 4; g++) begin
        k = $urandom % 16;
        c[4*g+:4] = k;
        c[4*g+16+:4] = k + 8;
      end
      @(posedge clock_in);
      mode_in <= m[1:0];
      mode_load_in <= 1;
      harm_req_in <= 1;
      codes_in <= c;
      rx_in <= $urandom;
      @(posedge clock_in);
      mode_load_in <= 0;
      mode_sel <= m[1:0];
      repeat (3) @(posedge clock_in);
      #1 check(mode_out, m);
      check(harm_en, m < 2);
      repeat (3) @(posedge sync);
      repeat (20) begin
        @(posedge fast);
        k = slot;
        repeat (8) @(posedge clock_in);
        #1 check(phase_out, 16'(k << m));
        if (m == 0) check(lo_out[3:0] ^ lo_out[7:4], 4'hf);
        if (m < 3) begin
          p = (k << m) % 16;
          s = 0;
          for (int g = 0; g < 8; g++) begin
            cd = c[4*g+:4];
            if (m == 0) begin
              b = ((p - cd + 16) % 16) < 8;
              v = (b == rx_in[g]) ? 127 : -127;
            end else begin
              v = (p < 8) ? wt(cd) : -wt(cd);
              v += (((p + 4) % 16) < 8) ? wt(cd - 4) : -wt(cd - 4);
              b = v >= 0;
              v = rx_in[g] ? v : -v;
            end
            e[g] = b;
            s += v;
          end
          check(lo_out, e);
          check({lo_i, lo_q}, {p < 8, ((p + 4) % 16) < 8});
          check({{2{sum_out[13]}}, sum_out}, 16'(s));
        end
      end
      $display("test mode %0d done", m);
    end
    complete_run;
  end
endmodule // cwlo_top_tb

// File: verilog/cwlo_channel.v
// One mixer channel: picks its LO phase and its I/Q weights.
// Assumes the sixteen phases and the I/Q clocks are on clock_in's domain.
`include "cwlo_regs.vh"
module cwlo_channel (
  // Clock and reset
  input wire clock_in,
  input wire resetn_in,
  // Phase inputs
  input wire [15:0] phases_in,
  input wire [3:0] code_in,
  input wire [1:0] mode_in,
  input wire lo_i_in,
  input wire lo_q_in,
  input wire rx_in,
  // Outputs
  output reg lo_out,
  output reg signed [9:0] mix_out
);
  // Cosine weight of step k, scaled by 127
  function signed [7:0] cwlo_cos;
    input [3:0] k;
    begin
      case (k)
        4'h0: cwlo_cos = 8'sh7f;
        4'h1: cwlo_cos = 8'sh75;
        4'h2: cwlo_cos = 8'sh5a;
        4'h3: cwlo_cos = 8'sh31;
        4'h4: cwlo_cos = 8'sh00;
        4'h5: cwlo_cos = -8'sh31;
        4'h6: cwlo_cos = -8'sh5a;
        4'h7: cwlo_cos = -8'sh75;
        4'h8: cwlo_cos = -8'sh7f;
        4'h9: cwlo_cos = -8'sh75;
        4'ha: cwlo_cos = -8'sh5a;
        4'hb: cwlo_cos = -8'sh31;
        4'hc: cwlo_cos = 8'sh00;
        4'hd: cwlo_cos = 8'sh31;
        4'he: cwlo_cos = 8'sh5a;
        default: cwlo_cos = 8'sh75;
      endcase
    end
  endfunction
  wire signed [7:0] w_cos;
  wire signed [7:0] w_sin;
  wire signed [7:0] i_term;
  wire signed [7:0] q_term;
  wire signed [8:0] i_sum;
  assign w_cos = cwlo_cos(code_in);
  assign w_sin = cwlo_cos(code_in - 4'h4);
  // I weighted by cos, Q by sin of the step
  assign i_term = lo_i_in ? w_cos : -w_cos; // [RULE11]
  assign q_term = lo_q_in ? w_sin : -w_sin; // [RULE11] [RULE12]
  assign i_sum = {i_term[7], i_term} + {q_term[7], q_term};
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      lo_out <= 1'b0;
      mix_out <= 10'sh000;
    end else if (mode_in == `CWLO_MODE_16X) begin
      lo_out <= phases_in[code_in]; // [RULE6] [RULE8]
      mix_out <= (phases_in[code_in] == rx_in) ? 10'sh07f : -10'sh07f;
    end else begin
      lo_out <= ~i_sum[8];
      mix_out <= rx_in ? {i_sum[8], i_sum} : -{i_sum[8], i_sum};
    end
  end
endmodule // cwlo_channel

// File: verilog/cwlo_regs.vh
// Constants for the CW local-oscillator phase distribution block.
// Assumes inclusion by bare name from the design files.
`ifndef CWLO_REGS_VH
`define CWLO_REGS_VH
`define CWLO_MODE_16X 2'h0
`define CWLO_MODE_8X 2'h1
`define CWLO_MODE_4X 2'h2
`define CWLO_MODE_1X 2'h3
`define CWLO_MODE_RESET 2'h0
`define CWLO_NUM_CH 8
`define CWLO_NUM_PH 16
`define CWLO_PH_W 4
`define CWLO_WGT_W 8
`define CWLO_SUM_W 14
`define CWLO_CYC_16X 4'h0
`define CWLO_CYC_8X 4'h1
`define CWLO_CYC_4X 4'h3
`endif

// File: verilog/cwlo_top.v
// CW LO phase generation and distribution to eight mixer channels.
// Assumes the fast and sync clocks come from pins and are oversampled here.
`include "cwlo_regs.vh"
// Contract
// RULE1 - Other side supplies fast and carrier clocks
// RULE2 - Reset selects sixteen-times mode
// RULE3 - Sixteen phases from fast clock
// RULE4 - Sync clock fixes LO starting phase
// RULE5 - Sync clock never clocks LO phases
// RULE6 - Sixteen-by-eight cross-point to mixers
// RULE7 - Selector inputs spaced one sixteenth period
// RULE8 - Channel phase matches its delay code
// RULE9 - Harmonic suppression only 16x and 8x
// RULE10 - I and Q exactly 90 degrees
// RULE11 - Cos/sin weighting gives sixteenth resolution
// RULE12 - 1x mode uses external I/Q clocks
// RULE13 - Other side aligns sync and fast edges
// RULE14 - Eight mixer outputs summed into one
// RULE15 - Four-bit code per channel, shared mode
// RULE16 - Sync edge realigns counter to zero
module cwlo_top (
  // Clock and reset
  input wire clock_in,
  input wire resetn_in,
  // CW clock pins
  input wire fast_clk_in,
  input wire sync_clk_in,
  input wire ext_i_in,
  input wire ext_q_in,
  // Configuration
  input wire [1:0] mode_in,
  input wire mode_load_in,
  input wire [31:0] codes_in,
  input wire harm_req_in,
  input wire [7:0] rx_in,
  // Outputs
  output reg [1:0] mode_out,
  output reg [7:0] lo_out,
  output reg lo_i_out,
  output reg lo_q_out,
  output reg harm_en_out,
  output reg [3:0] phase_out,
  output reg signed [13:0] sum_out
);
  reg [1:0] fast_s1_reg;
  reg fast_d_reg;
  reg [1:0] sync_s_reg;
  reg sync_d_reg;
  reg [1:0] ei_s_reg;
  reg [1:0] eq_s_reg;
  reg [1:0] mode_reg;
  reg [3:0] cnt_reg;
  reg [3:0] cnt_next;
  wire [15:0] phases;
  reg lo_i;
  reg lo_q;
  reg [3:0] fast_per;
  integer n;
  reg signed [13:0] sum_next;
  wire fast_edge;
  wire sync_edge;
  wire [7:0] ch_lo;
  wire [79:0] ch_mix;
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      fast_s1_reg <= 2'h0;
      sync_s_reg <= 2'h0;
      ei_s_reg <= 2'h0;
      eq_s_reg <= 2'h0;
      fast_d_reg <= 1'b0;
      sync_d_reg <= 1'b0;
    end else begin
      fast_s1_reg <= {fast_s1_reg[0], fast_clk_in};
      sync_s_reg <= {sync_s_reg[0], sync_clk_in};
      ei_s_reg <= {ei_s_reg[0], ext_i_in};
      eq_s_reg <= {eq_s_reg[0], ext_q_in};
      fast_d_reg <= fast_s1_reg[1];
      sync_d_reg <= sync_s_reg[1];
    end
  end
  assign fast_edge = fast_s1_reg[1] & ~fast_d_reg;
  assign sync_edge = sync_s_reg[1] & ~sync_d_reg;
  always @* begin
    case (mode_reg)
      `CWLO_MODE_8X: fast_per = `CWLO_CYC_8X;
      `CWLO_MODE_4X: fast_per = `CWLO_CYC_4X;
      default: fast_per = `CWLO_CYC_16X;
    endcase
  end
  // Phase counter: advances on fast edges except in 1x mode, sync only realigns it
  always @* begin
    cnt_next = cnt_reg;
    if (sync_edge) begin
      cnt_next = 4'h0; // [RULE4] [RULE16] [RULE5]
    end else if (fast_edge && mode_reg != `CWLO_MODE_1X) begin
      cnt_next = cnt_reg + fast_per + 4'h1; // [RULE3]
    end
  end
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      mode_reg <= `CWLO_MODE_RESET; // [RULE2]
      cnt_reg <= 4'h0;
    end else begin
      if (mode_load_in) begin
        mode_reg <= mode_in; // [RULE15]
      end
      cnt_reg <= cnt_next;
    end
  end
  genvar g;
  generate
    for (g = 0; g < `CWLO_NUM_PH; g = g + 1) begin : g_ph
      // Phase g is the carrier delayed by g sixteenths
      localparam integer PH_OFS = g;
      wire [3:0] ph_diff;
      assign ph_diff = cnt_reg - PH_OFS[3:0];
      assign phases[g] = ~ph_diff[3];
    end
  endgenerate
  // I and Q a quarter period apart, external in 1x mode
  always @* begin
    if (mode_reg == `CWLO_MODE_1X) begin
      lo_i = ei_s_reg[1]; // [RULE12]
      lo_q = eq_s_reg[1];
    end else begin
      lo_i = ~cnt_reg[3]; // [RULE10]
      lo_q = ~(cnt_reg[3] ^ cnt_reg[2]);
    end
  end
  generate
    for (g = 0; g < `CWLO_NUM_CH; g = g + 1) begin : g_ch
      cwlo_channel u_ch (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .phases_in(phases), // [RULE7]
        .code_in(codes_in[4*g+3:4*g]), // [RULE15]
        .mode_in(mode_reg),
        .lo_i_in(lo_i),
        .lo_q_in(lo_q),
        .rx_in(rx_in[g]),
        .lo_out(ch_lo[g]),
        .mix_out(ch_mix[10*g+9:10*g])
      );
    end
  endgenerate
  always @* begin
    sum_next = 14'sh0000;
    for (n = 0; n < `CWLO_NUM_CH; n = n + 1) begin
      sum_next = sum_next + {{4{ch_mix[10*n+9]}}, ch_mix[10*n +: 10]}; // [RULE14]
    end
  end
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      mode_out <= `CWLO_MODE_RESET;
      lo_out <= 8'h00;
      lo_i_out <= 1'b0;
      lo_q_out <= 1'b0;
      harm_en_out <= 1'b0;
      phase_out <= 4'h0;
      sum_out <= 14'sh0000;
    end else begin
      mode_out <= mode_reg;
      lo_out <= ch_lo;
      lo_i_out <= lo_i;
      lo_q_out <= lo_q;
      harm_en_out <= harm_req_in & ~mode_reg[1]; // [RULE9]
      phase_out <= cnt_reg;
      sum_out <= sum_next;
    end
  end
endmodule // cwlo_top
